/* logic/arp_config_regs.sv */
// Purpose: range, power mode, timestamp, reference output and divider registers
// Assumes: companion power and calibration logic lives elsewhere
// Notes: unsafe-write pulses flag host ordering slips, they block nothing
`timescale 1ns/1ps
module arp_config_regs (
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic        spi_clk_i,
	input  wire logic        spi_cs_n_i,
	input  wire logic        spi_data_i,
	output logic             spi_data_o,
	output logic             spi_data_oe_o,
	input  wire logic        synth_enable_i,
	input  wire logic        cal_enable_i,
	input  wire logic        serial_link_enable_i,
	input  wire logic        synth_reset_bit_i,
	output logic [15:0]      analog_full_scale_setting_o,
	output logic [7:0]       power_mode_code_o,
	output logic             low_power_mode_o,
	output logic             power_mode_reserved_o,
	output logic             timestamp_receiver_enable_o,
	output logic             timestamp_termination_mode_o,
	output logic             reference_clock_output_on_o,
	output logic [1:0]       div_p_code_o,
	output logic [1:0]       div_v_code_o,
	output logic [5:0]       div_n_o,
	output logic [2:0]       div_p_ratio_o,
	output logic [2:0]       div_v_ratio_o,
	output logic             div_reserved_o,
	output logic             mode_write_unsafe_o,
	output logic             div_write_unsafe_o
);

	// ----------------------------------------
	// serial port
	// ----------------------------------------
	logic        wr_stb;
	logic [14:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;

	arp_serial_port u_port (
		.clock_i       (clock_i),
		.reset_i       (reset_i),
		.spi_clk_i     (spi_clk_i),
		.spi_cs_n_i    (spi_cs_n_i),
		.spi_data_i    (spi_data_i),
		.spi_data_o    (spi_data_o),
		.spi_data_oe_o (spi_data_oe_o),
		.wr_stb_o      (wr_stb),
		.addr_o        (addr),
		.wdata_o       (wdata),
		.rdata_i       (rdata)
	);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// returns {hit, index}
	function automatic logic [3:0] map_addr(input logic [14:0] a);
		if (a == arp_pkg::ADDR_FS_LO) map_addr = {1'b1, arp_pkg::IDX_FS_LO};
		else if (a == arp_pkg::ADDR_FS_HI) map_addr = {1'b1, arp_pkg::IDX_FS_HI};
		else if (a == arp_pkg::ADDR_PM) map_addr = {1'b1, arp_pkg::IDX_PM};
		else if (a == arp_pkg::ADDR_TS) map_addr = {1'b1, arp_pkg::IDX_TS};
		else if (a == arp_pkg::ADDR_RO) map_addr = {1'b1, arp_pkg::IDX_RO};
		else if (a == arp_pkg::ADDR_VP) map_addr = {1'b1, arp_pkg::IDX_VP};
		else if (a == arp_pkg::ADDR_N) map_addr = {1'b1, arp_pkg::IDX_N};
		else map_addr = 4'h0;
	endfunction

	wire [3:0] hit_idx = map_addr(addr);
	wire       hit     = hit_idx[3];
	wire [2:0] idx     = hit_idx[2:0];

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] bank_reg [arp_pkg::NUM_BYTES];

	genvar gi;
	generate
		for (gi = 0; gi < arp_pkg::NUM_BYTES; gi++) begin : g_byte
			always_ff @(posedge clock_i or posedge reset_i) begin
				if (reset_i) begin
					bank_reg[gi] <= arp_pkg::RST_BANK[gi*8 +: 8];
				end else if (wr_stb && hit && idx == 3'(gi)) begin
					bank_reg[gi] <= wdata;
				end
			end
		end
	endgenerate

	assign rdata = hit ? bank_reg[idx] : arp_pkg::RD_UNMAPPED;

	// ----------------------------------------
	// exported settings
	// ----------------------------------------
	logic [1:0] synth_en_sync_reg;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			synth_en_sync_reg <= 2'h0;
		end else begin
			synth_en_sync_reg <= {synth_en_sync_reg[0], synth_enable_i};
		end
	end

	wire [7:0] vp_byte = bank_reg[arp_pkg::IDX_VP];
	wire [7:0] n_byte  = bank_reg[arp_pkg::IDX_N];

	// one code for all channels, code passed straight to the front end
	assign analog_full_scale_setting_o = {bank_reg[arp_pkg::IDX_FS_HI],
	                                      bank_reg[arp_pkg::IDX_FS_LO]};
	assign power_mode_code_o     = bank_reg[arp_pkg::IDX_PM];
	assign low_power_mode_o      = power_mode_code_o == arp_pkg::PM_LOW_POWER;
	assign power_mode_reserved_o = !low_power_mode_o
	                               && power_mode_code_o != arp_pkg::PM_HIGH_PERF;
	assign timestamp_receiver_enable_o  = bank_reg[arp_pkg::IDX_TS][arp_pkg::TS_RECV_BIT];
	assign timestamp_termination_mode_o = bank_reg[arp_pkg::IDX_TS][arp_pkg::TS_TERM_BIT];
	assign reference_clock_output_on_o = bank_reg[arp_pkg::IDX_RO][arp_pkg::RO_EN_BIT]
	                                     & synth_en_sync_reg[1];
	assign div_p_code_o = vp_byte[arp_pkg::P_LSB +: 2];
	assign div_v_code_o = vp_byte[arp_pkg::V_LSB +: 2];
	assign div_n_o      = n_byte[arp_pkg::N_LSB +: 6];

	// ----------------------------------------
	// divider ratio decode
	// ----------------------------------------
	logic [2:0] p_ratio_next;
	logic [2:0] v_ratio_next;

	// P ratio, reserved code gives zero
	always_comb begin
		case (div_p_code_o)
			2'h0:    p_ratio_next = 3'h1;
			2'h1:    p_ratio_next = 3'h2;
			2'h2:    p_ratio_next = 3'h4;
			default: p_ratio_next = 3'h0;
		endcase
	end

	// V ratio, reserved code gives zero
	always_comb begin
		case (div_v_code_o)
			2'h0:    v_ratio_next = 3'h5;
			2'h1:    v_ratio_next = 3'h4;
			2'h2:    v_ratio_next = 3'h3;
			default: v_ratio_next = 3'h0;
		endcase
	end

	wire div_reserved_next = p_ratio_next == 3'h0 || v_ratio_next == 3'h0 || div_n_o == 6'h00;
	wire pm_write  = wr_stb && hit && idx == arp_pkg::IDX_PM;
	wire div_write = wr_stb && hit && (idx == arp_pkg::IDX_VP || idx == arp_pkg::IDX_N);

	// ratios one cycle behind the fields
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			div_p_ratio_o       <= 3'h1;
			div_v_ratio_o       <= 3'h5;
			div_reserved_o      <= 1'b0;
			mode_write_unsafe_o <= 1'b0;
			div_write_unsafe_o  <= 1'b0;
		end else begin
			div_p_ratio_o       <= p_ratio_next;
			div_v_ratio_o       <= v_ratio_next;
			div_reserved_o      <= div_reserved_next;
			// flag mode change with calibration or link still on
			mode_write_unsafe_o <= pm_write && (cal_enable_i || serial_link_enable_i);
			// flag divider change outside synth reset
			div_write_unsafe_o  <= div_write && !synth_reset_bit_i;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_fs_reset;
		@(posedge clock_i) disable iff (reset_i)
		$fell(reset_i) |-> analog_full_scale_setting_o == 16'hA000 && power_mode_code_o == 8'h4B;
	endproperty
	a_fs_reset: assert property (p_fs_reset) else $error("bank defaults wrong after reset");

	property p_write_lands;
		@(posedge clock_i) disable iff (reset_i)
		(wr_stb && hit) |=> bank_reg[$past(idx)] == $past(wdata);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("written byte not stored");

	property p_low_power;
		@(posedge clock_i) disable iff (reset_i)
		low_power_mode_o |-> power_mode_code_o == 8'h46 && !power_mode_reserved_o;
	endproperty
	a_low_power: assert property (p_low_power) else $error("low power decode wrong");

	property p_ts_enable;
		@(posedge clock_i) disable iff (reset_i)
		(wr_stb && hit && idx == 3'h3) |=> timestamp_receiver_enable_o == $past(wdata[0]);
	endproperty
	a_ts_enable: assert property (p_ts_enable) else $error("timestamp enable not following write");

	property p_ref_out;
		@(posedge clock_i) disable iff (reset_i)
		(synth_en_sync_reg[1] && bank_reg[4][0]) |-> reference_clock_output_on_o;
	endproperty
	a_ref_out: assert property (p_ref_out) else $error("reference output not driven");

	// output may only follow the enable pin through both sync stages
	property p_ref_sync;
		@(posedge clock_i) disable iff (reset_i)
		reference_clock_output_on_o |-> $past(synth_enable_i, 2);
	endproperty
	a_ref_sync: assert property (p_ref_sync) else $error("reference output ahead of synth enable");

	property p_p_ratio;
		@(posedge clock_i) disable iff (reset_i)
		(div_p_code_o == 2'h2) ##1 (div_p_code_o == 2'h2) |-> div_p_ratio_o == 3'h4;
	endproperty
	a_p_ratio: assert property (p_p_ratio) else $error("P ratio for code 2 is not 4");

	property p_v_ratio;
		@(posedge clock_i) disable iff (reset_i)
		$stable(div_v_code_o) && div_v_code_o == 2'h0 |-> div_v_ratio_o == 3'h5;
	endproperty
	a_v_ratio: assert property (p_v_ratio) else $error("V ratio for code 0 is not 5");

	property p_n_reserved;
		@(posedge clock_i) disable iff (reset_i)
		(div_n_o == 6'h00) |=> div_reserved_o;
	endproperty
	a_n_reserved: assert property (p_n_reserved) else $error("N of zero not flagged");

endmodule

/* logic/arp_serial_port.sv */
// Purpose: serial control port slave, byte access, mode 0
// Assumes: serial clock well below a quarter of clock_i
// Notes: pins are resynchronised; first bit high means read
`timescale 1ns/1ps
module arp_serial_port (
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	input  wire logic        spi_clk_i,
	input  wire logic        spi_cs_n_i,
	input  wire logic        spi_data_i,
	output logic             spi_data_o,
	output logic             spi_data_oe_o,
	output logic             wr_stb_o,
	output logic [14:0]      addr_o,
	output logic [7:0]       wdata_o,
	input  wire logic [7:0]  rdata_i
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0]  clk_sync_reg;
	logic [1:0]  cs_n_sync_reg;
	logic [1:0]  din_sync_reg;
	logic        clk_prev_reg;
	logic [4:0]  bit_cnt_reg;
	logic        read_reg;
	logic [22:0] shift_reg;
	logic [6:0]  rd_shift_reg;

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			clk_sync_reg  <= 2'h0;
			cs_n_sync_reg <= 2'h3;
			din_sync_reg  <= 2'h0;
			clk_prev_reg  <= 1'b0;
		end else begin
			clk_sync_reg  <= {clk_sync_reg[0], spi_clk_i};
			cs_n_sync_reg <= {cs_n_sync_reg[0], spi_cs_n_i};
			din_sync_reg  <= {din_sync_reg[0], spi_data_i};
			clk_prev_reg  <= clk_sync_reg[1];
		end
	end

	localparam logic [4:0] FRAME_BITS_W = arp_pkg::FRAME_BITS;

	wire active   = ~cs_n_sync_reg[1];
	wire din      = din_sync_reg[1];
	wire rise     = active & clk_sync_reg[1] & ~clk_prev_reg & (bit_cnt_reg < FRAME_BITS_W);
	wire fall     = active & ~clk_sync_reg[1] & clk_prev_reg;
	wire last_bit = bit_cnt_reg == FRAME_BITS_W - 5'h01;

	// ----------------------------------------
	// frame shifter
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			bit_cnt_reg  <= 5'h00;
			read_reg     <= 1'b0;
			shift_reg    <= 23'h000000;
			addr_o       <= 15'h0000;
			wdata_o      <= 8'h00;
			wr_stb_o     <= 1'b0;
			rd_shift_reg <= 7'h00;
			spi_data_o   <= 1'b0;
		end else begin
			wr_stb_o <= 1'b0;
			if (!active) begin
				bit_cnt_reg <= 5'h00;
			end else if (rise) begin
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
				shift_reg   <= {shift_reg[21:0], din};
				if (bit_cnt_reg == 5'h00) begin
					read_reg <= din;
				end
				if (bit_cnt_reg == arp_pkg::FRAME_ADDR_END - 5'h01) begin
					addr_o <= {shift_reg[13:0], din};
				end
				if (last_bit && !read_reg) begin
					wdata_o  <= {shift_reg[6:0], din};
					wr_stb_o <= 1'b1;
				end
			end
			// read data changes on the falling edge, host samples on rising
			if (fall && read_reg) begin
				if (bit_cnt_reg == arp_pkg::FRAME_ADDR_END) begin
					spi_data_o   <= rdata_i[7];
					rd_shift_reg <= rdata_i[6:0];
				end else if (bit_cnt_reg > arp_pkg::FRAME_ADDR_END) begin
					spi_data_o   <= rd_shift_reg[6];
					rd_shift_reg <= {rd_shift_reg[5:0], 1'b0};
				end
			end
		end
	end

	assign spi_data_oe_o = active & read_reg & (bit_cnt_reg >= arp_pkg::FRAME_ADDR_END);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_wr_single;
		@(posedge clock_i) disable iff (reset_i)
		wr_stb_o |=> !wr_stb_o;
	endproperty
	a_wr_single: assert property (p_wr_single) else $error("write strobe longer than one cycle");

	property p_no_wr_on_read;
		@(posedge clock_i) disable iff (reset_i)
		(rise && last_bit && read_reg) |=> !wr_stb_o;
	endproperty
	a_no_wr_on_read: assert property (p_no_wr_on_read) else $error("read frame caused a write");

endmodule

/* shared/arp_pkg.sv */
// Purpose: constants for the range, power mode and synthesizer divider register bank
// Assumes: byte-wide serial control port, 15-bit register address
// Notes: 16-bit full-scale register spans two byte addresses, low byte first
//
// Summary of operation
// - full-scale code 16 bits, reset 0xA000, all channels
// - code 0x2000..0xFFFF spans 500..1000 mVpp
// - power code 0x46 low, 0x4B high
// - timestamp bit 0 enables receiver, reset off
// - reference output follows enable and synth enable
// - P divider codes 0..2 give 1,2,4
// - V divider codes 0..2 give 5,4,3
// - N divider value 1..63, reset 32
package arp_pkg;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [14:0] ADDR_FS_LO = 15'h0030;
	localparam logic [14:0] ADDR_FS_HI = 15'h0031;
	localparam logic [14:0] ADDR_PM    = 15'h0037;
	localparam logic [14:0] ADDR_TS    = 15'h003B;
	localparam logic [14:0] ADDR_RO    = 15'h003C;
	localparam logic [14:0] ADDR_VP    = 15'h003D;
	localparam logic [14:0] ADDR_N     = 15'h003E;

	// ----------------------------------------
	// storage indices and reset values
	// ----------------------------------------
	localparam int          NUM_BYTES = 7;
	localparam logic [2:0]  IDX_FS_LO = 3'h0;
	localparam logic [2:0]  IDX_FS_HI = 3'h1;
	localparam logic [2:0]  IDX_PM    = 3'h2;
	localparam logic [2:0]  IDX_TS    = 3'h3;
	localparam logic [2:0]  IDX_RO    = 3'h4;
	localparam logic [2:0]  IDX_VP    = 3'h5;
	localparam logic [2:0]  IDX_N     = 3'h6;
	localparam logic [15:0] RST_FS    = 16'hA000;
	localparam logic [7:0]  RST_PM    = 8'h4B;
	localparam logic [7:0]  RST_TS    = 8'h00;
	localparam logic [7:0]  RST_RO    = 8'h01;
	localparam logic [7:0]  RST_VP    = 8'h00;
	localparam logic [7:0]  RST_N     = 8'h20;
	// index 0 in the low byte
	localparam logic [55:0] RST_BANK  = {RST_N, RST_VP, RST_RO, RST_TS, RST_PM, RST_FS};
	localparam logic [7:0]  RD_UNMAPPED = 8'h00;

	// ----------------------------------------
	// fields and codes
	// ----------------------------------------
	localparam int         TS_RECV_BIT  = 0;
	localparam int         TS_TERM_BIT  = 1;
	localparam int         RO_EN_BIT    = 0;
	localparam int         P_LSB        = 2;
	localparam int         V_LSB        = 0;
	localparam int         N_LSB        = 0;
	localparam logic [7:0] PM_LOW_POWER = 8'h46;
	localparam logic [7:0] PM_HIGH_PERF = 8'h4B;

	// ----------------------------------------
	// serial frame: rw bit, 15 address bits, 8 data bits
	// ----------------------------------------
	localparam logic [4:0] FRAME_ADDR_END = 5'h10;
	localparam logic [4:0] FRAME_BITS     = 5'h18;

endpackage

/* tb/arp_host_model.sv */
// Purpose: serial control port host for the range and divider bank
// Assumes: clock_i at 100 MHz, serial phases of six clocks
// Notes: serial clock stands low between frames
`timescale 1ns/1ps
module arp_host_model (
	input  wire logic clock_i,
	input  wire logic sdo_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o
);
	localparam int HALF = 6;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o  = 1'b0;
	end
	// ----------------------------------------
	// one frame: rw, address, data
	// ----------------------------------------
	// caller passes defaults in reserved bits
	task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		logic [23:0] f;
		f = {rw, a, wd};
		rd = 8'h00;
		@(negedge clock_i);
		cs_n_o = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			// released line toggles during read data
			sdi_o = (rw && i < 8) ? ~sdi_o : f[i];
			repeat (HALF) @(negedge clock_i);
			sclk_o = 1'b1;
			if (i < 8)
				rd = {rd[6:0], sdo_i};
			repeat (HALF) @(negedge clock_i);
			sclk_o = 1'b0;
		end
		cs_n_o = 1'b1;
		sdi_o  = ~sdi_o;
		repeat (10) @(negedge clock_i);
	endtask
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the configuration register bank
// Assumes: host model drives the serial pins at falling clock edges
// Notes: side inputs change at falling edges only
`timescale 1ns/1ps
module tb_top;
	logic clock_i, reset_i, synth_en, cal_en, link_en, synth_rst;
	logic sclk, cs_n, sdi, dev_o, dev_oe, lp, pm_res, ts_r, ts_t, ref_on, dres, mpu, dpu;
	logic [15:0] fs;
	logic [7:0]  pm;
	logic [1:0]  pc, vc;
	logic [5:0]  dn;
	logic [2:0]  pr, vr;
	int          err_count, cmp_count, mode_pulses, div_pulses;
	// resolved three-state data line
	wire         sdio = dev_oe ? dev_o : sdi;
	localparam logic [14:0] ADDRS [7] = '{arp_pkg::ADDR_FS_LO, arp_pkg::ADDR_FS_HI,
		arp_pkg::ADDR_PM, arp_pkg::ADDR_TS, arp_pkg::ADDR_RO, arp_pkg::ADDR_VP, arp_pkg::ADDR_N};

	arp_host_model HOST (.clock_i(clock_i), .sdo_i(sdio), .sclk_o(sclk), .cs_n_o(cs_n),
		.sdi_o(sdi));
	arp_config_regs DUT (.clock_i(clock_i), .reset_i(reset_i), .spi_clk_i(sclk),
		.spi_cs_n_i(cs_n), .spi_data_i(sdio), .spi_data_o(dev_o), .spi_data_oe_o(dev_oe),
		.synth_enable_i(synth_en), .cal_enable_i(cal_en), .serial_link_enable_i(link_en),
		.synth_reset_bit_i(synth_rst), .analog_full_scale_setting_o(fs),
		.power_mode_code_o(pm), .low_power_mode_o(lp), .power_mode_reserved_o(pm_res),
		.timestamp_receiver_enable_o(ts_r), .timestamp_termination_mode_o(ts_t),
		.reference_clock_output_on_o(ref_on), .div_p_code_o(pc), .div_v_code_o(vc),
		.div_n_o(dn), .div_p_ratio_o(pr), .div_v_ratio_o(vr), .div_reserved_o(dres),
		.mode_write_unsafe_o(mpu), .div_write_unsafe_o(dpu));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (mpu === 1'b1) mode_pulses++;
		if (dpu === 1'b1) div_pulses++;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] r;
		HOST.xfer(1'b0, a, d, r);
	endtask
	task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
		logic [7:0] r;
		HOST.xfer(1'b1, a, 8'h00, r);
		check("readback", r, exp);
	endtask
	task automatic complete_run;
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults;
		check("fs", fs, arp_pkg::RST_FS);
		check("pm", pm, arp_pkg::RST_PM);
		check("ts", {ts_t, ts_r}, 16'h0000);
		check("p ratio", pr, 16'h0001);
		check("v ratio", vr, 16'h0005);
		check("n", dn, 16'h0020);
		for (int k = 0; k < 7; k++)
			rd_chk(ADDRS[k], arp_pkg::RST_BANK[8*k +: 8]);
	endtask
	task automatic t_fs;
		wr(arp_pkg::ADDR_FS_LO, 8'hFF);
		wr(arp_pkg::ADDR_FS_HI, 8'hFF);
		check("fs max", fs, 16'hFFFF);
		wr(arp_pkg::ADDR_FS_LO, 8'h00);
		wr(arp_pkg::ADDR_FS_HI, 8'h20);
		check("fs min", fs, 16'h2000);
		rd_chk(arp_pkg::ADDR_FS_HI, 8'h20);
	endtask
	task automatic t_pm;
		logic [7:0] codes [3] = '{8'h46, 8'h4B, 8'h47};
		// cal and link enables low before each of the first three mode writes
		@(negedge clock_i) {cal_en, link_en} = 2'b00;
		for (int k = 0; k < 3; k++) begin
			// companion power registers sit outside this bank
			wr(arp_pkg::ADDR_PM, codes[k]);
			check("low power", lp, {15'h0, k == 0});
			check("reserved", pm_res, {15'h0, k == 2});
			// calibration runs after the mode change
			@(negedge clock_i) cal_en = 1'b1;
			@(negedge clock_i) cal_en = 1'b0;
		end
		check("mode flags", 16'(mode_pulses), 16'h0000);
		@(negedge clock_i) link_en = 1'b1;
		wr(arp_pkg::ADDR_PM, 8'h4B);
		@(negedge clock_i) link_en = 1'b0;
		check("mode flags", 16'(mode_pulses), 16'h0001);
		rd_chk(arp_pkg::ADDR_PM, 8'h4B);
	endtask
	task automatic t_ts_ref;
		wr(arp_pkg::ADDR_TS, 8'h01);
		check("ts on", {ts_t, ts_r}, 16'h0001);
		wr(arp_pkg::ADDR_TS, 8'h02);
		check("ts term", {ts_t, ts_r}, 16'h0002);
		check("ref idle", ref_on, 16'h0000);
		@(negedge clock_i) synth_en = 1'b1;
		repeat (5) @(negedge clock_i);
		check("ref on", ref_on, 16'h0001);
		wr(arp_pkg::ADDR_RO, 8'h00);
		check("ref off", ref_on, 16'h0000);
	endtask
	task automatic t_div;
		logic [2:0] pe [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
		logic [2:0] ve [4] = '{3'h5, 3'h4, 3'h3, 3'h0};
		logic [5:0] nv [3] = '{6'h01, 6'h3F, 6'h00};
		// synth reset held before any divider change
		@(negedge clock_i) synth_rst = 1'b1;
		for (int p = 0; p < 4; p++) begin
			wr(arp_pkg::ADDR_VP, {4'h0, p[1:0], 2'(3 - p)});
			check("p code", pc, 16'(p));
			check("v code", vc, 16'(3 - p));
			check("p ratio", pr, pe[p]);
			check("v ratio", vr, ve[3 - p]);
			check("div reserved", dres, {15'h0, p == 0 || p == 3});
		end
		wr(arp_pkg::ADDR_VP, 8'h00);
		for (int k = 0; k < 3; k++) begin
			wr(arp_pkg::ADDR_N, {2'h0, nv[k]});
			check("n", dn, nv[k]);
			check("n reserved", dres, {15'h0, k == 2});
		end
		check("div flags", 16'(div_pulses), 16'h0000);
		@(negedge clock_i) synth_rst = 1'b0;
		wr(arp_pkg::ADDR_N, 8'h20);
		check("div flags", 16'(div_pulses), 16'h0001);
	endtask
	task automatic t_unmapped_reset;
		wr(15'h0040, 8'h55);
		rd_chk(15'h0040, arp_pkg::RD_UNMAPPED);
		@(negedge clock_i) reset_i = 1'b1;
		repeat (2) @(negedge clock_i);
		reset_i = 1'b0;
		repeat (5) @(negedge clock_i);
		t_defaults();
	endtask

	initial begin
		{reset_i, synth_en, cal_en, link_en, synth_rst} = 5'h10;
		{err_count, cmp_count, mode_pulses, div_pulses} = '0;
		repeat (5) @(negedge clock_i);
		reset_i = 1'b0;
		repeat (5) @(negedge clock_i);
		t_defaults();
		t_fs();
		t_pm();
		t_ts_ref();
		t_div();
		t_unmapped_reset();
		complete_run();
	end
	initial begin
		// about 40 frames of some 300 clocks each, with ample margin
		#400us;
		err_count++;
		complete_run();
	end
endmodule
